// [cperg_regs.sv]
// Channel enable, output slot enable and power control registers with status.
// Assumes the control port decoder delivers byte address, data and strobes on clk.
`timescale 1ns/1ps
module cperg_regs #(
	parameter int CHANNELS = 2,
	parameter logic [cperg_pkg::RAMP_WIDTH-1:0] RAMP_CYCLES =
		cperg_pkg::RAMP_WIDTH'(cperg_pkg::RAMP_CYCLES)
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	input wire logic device_sleep,
	output logic input_ch1_enable,
	output logic input_ch2_enable,
	output logic out_slot1_enable,
	output logic out_slot2_enable,
	output logic mic_bias_power_on,
	output logic converter_power_on,
	output logic pll_power_on,
	output logic dynamic_channel_power_enable,
	output logic ch1_powered,
	output logic ch2_powered,
	output logic [2:0] device_mode_field
);
	cperg_pkg::cperg_regs_type r_q;
	cperg_pkg::cperg_regs_type r_d;
	logic [CHANNELS-1:0] powered;
	logic [CHANNELS-1:0] chan_enable;
	logic [7:0] status0;
	logic [7:0] status1;
	logic any_powered;

	assign chan_enable[0] = r_q.input_enable[cperg_pkg::BIT_CH1];
	assign chan_enable[1] = r_q.input_enable[cperg_pkg::BIT_CH2];
	assign any_powered = |powered;

	always_comb begin
		status0 = cperg_pkg::RST_CHANNEL_POWER_STATUS;
		status0[cperg_pkg::BIT_CH1] = powered[0];
		status0[cperg_pkg::BIT_CH2] = powered[1];
		status1 = 8'h00;
		status1[cperg_pkg::MODE_LSB +: 3] = r_q.mode;
	end

	always_comb begin
		r_d = r_q;
		if (reg_write) begin
			// Reserved bits are stored as written, except power configuration bit 0, which is masked to zero; software keeps them at reset value
			if (reg_addr == cperg_pkg::ADDR_INPUT_CHANNEL_ENABLE) begin
				r_d.input_enable = reg_wdata;
			end else if (reg_addr == cperg_pkg::ADDR_OUTPUT_SLOT_ENABLE) begin
				r_d.slot_enable = reg_wdata;
			end else if (reg_addr == cperg_pkg::ADDR_POWER_CONFIGURATION) begin
				r_d.power_cfg = reg_wdata & cperg_pkg::POWER_CONFIGURATION_WMASK;
			end
		end

		// Without dynamic control the channel set is frozen while any channel records
		if (!r_q.power_cfg[cperg_pkg::BIT_CONVERTER]) begin
			r_d.target = '0;
		end else if (r_q.power_cfg[cperg_pkg::BIT_DYNAMIC]) begin
			r_d.target = chan_enable;
		end else if (!any_powered && (r_q.target == '0)) begin
			r_d.target = chan_enable;
		end

		if (device_sleep) begin
			r_d.mode = cperg_pkg::MODE_SLEEP;
		end else if (any_powered) begin
			r_d.mode = cperg_pkg::MODE_ACTIVE_ON;
		end else begin
			r_d.mode = cperg_pkg::MODE_ACTIVE_IDLE;
		end

		if (reg_read) begin
			if (reg_addr == cperg_pkg::ADDR_INPUT_CHANNEL_ENABLE) begin
				r_d.rd_data = r_q.input_enable;
			end else if (reg_addr == cperg_pkg::ADDR_OUTPUT_SLOT_ENABLE) begin
				r_d.rd_data = r_q.slot_enable;
			end else if (reg_addr == cperg_pkg::ADDR_POWER_CONFIGURATION) begin
				r_d.rd_data = r_q.power_cfg;
			end else if (reg_addr == cperg_pkg::ADDR_CHANNEL_POWER_STATUS) begin
				r_d.rd_data = status0;
			end else if (reg_addr == cperg_pkg::ADDR_DEVICE_MODE_STATUS) begin
				r_d.rd_data = status1;
			end else begin
				r_d.rd_data = cperg_pkg::READ_UNMAPPED;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			r_q.input_enable <= cperg_pkg::RST_INPUT_CHANNEL_ENABLE;
			r_q.slot_enable <= cperg_pkg::RST_OUTPUT_SLOT_ENABLE;
			r_q.power_cfg <= cperg_pkg::RST_POWER_CONFIGURATION;
			r_q.target <= '0;
			r_q.mode <= cperg_pkg::RST_DEVICE_MODE_STATUS[cperg_pkg::MODE_LSB +: 3];
			r_q.rd_data <= 8'h00;
		end else begin
			r_q <= r_d;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < CHANNELS; gi++) begin : g_chan
			cperg_chan_seq #(
				.RAMP_CYCLES(RAMP_CYCLES)
			) u_seq (
				.clk(clk),
				.reset(reset),
				.power_request(r_q.target[gi]),
				.powered(powered[gi])
			);
		end
	endgenerate

	assign reg_rdata = r_q.rd_data;
	assign input_ch1_enable = r_q.input_enable[cperg_pkg::BIT_CH1];
	assign input_ch2_enable = r_q.input_enable[cperg_pkg::BIT_CH2];
	assign out_slot1_enable = r_q.slot_enable[cperg_pkg::BIT_CH1];
	assign out_slot2_enable = r_q.slot_enable[cperg_pkg::BIT_CH2];
	assign mic_bias_power_on = r_q.power_cfg[cperg_pkg::BIT_MIC_BIAS];
	assign converter_power_on = r_q.power_cfg[cperg_pkg::BIT_CONVERTER];
	assign pll_power_on = r_q.power_cfg[cperg_pkg::BIT_PLL];
	assign dynamic_channel_power_enable = r_q.power_cfg[cperg_pkg::BIT_DYNAMIC];
	assign ch1_powered = powered[0];
	assign ch2_powered = powered[1];
	assign device_mode_field = r_q.mode;
endmodule

// [cperg_pkg.sv]
// Constants and types shared by the channel power and enable register block.
// Assumes a byte-wide control port with one-cycle write and read strobes.
//
// Overview of operation
// - Input-enable register, bit 7 enables channel 1
// - Input-enable bit 6 enables channel 2
// - Output-slot bit 7 drives slot 1, else tri-state
// - Output-slot bit 6 drives slot 2, else tri-state
// - Power bit 7 switches microphone bias supply
// - Power bit 6 switches all enabled channels
// - Power bit 5 switches the PLL
// - Dynamic bit clear: no per-channel change recording
// - Dynamic bit set: per-channel change while recording
// - Status bits 7,6 report channel power state
// - Second status register resets to 0x80
// - Mode field: 4 sleep, 6 idle, 7 channel on
package cperg_pkg;
	localparam logic [7:0] ADDR_INPUT_CHANNEL_ENABLE = 8'h73;
	localparam logic [7:0] ADDR_OUTPUT_SLOT_ENABLE = 8'h74;
	localparam logic [7:0] ADDR_POWER_CONFIGURATION = 8'h75;
	localparam logic [7:0] ADDR_CHANNEL_POWER_STATUS = 8'h76;
	localparam logic [7:0] ADDR_DEVICE_MODE_STATUS = 8'h77;

	localparam logic [7:0] RST_INPUT_CHANNEL_ENABLE = 8'hFC;
	localparam logic [7:0] RST_OUTPUT_SLOT_ENABLE = 8'h00;
	localparam logic [7:0] RST_POWER_CONFIGURATION = 8'h00;
	localparam logic [7:0] RST_CHANNEL_POWER_STATUS = 8'h00;
	localparam logic [7:0] RST_DEVICE_MODE_STATUS = 8'h80;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;

	// Power configuration bit 0 is read-only and reads zero
	localparam logic [7:0] POWER_CONFIGURATION_WMASK = 8'hFE;

	localparam int BIT_CH1 = 7;
	localparam int BIT_CH2 = 6;
	localparam int BIT_MIC_BIAS = 7;
	localparam int BIT_CONVERTER = 6;
	localparam int BIT_PLL = 5;
	localparam int BIT_DYNAMIC = 4;
	localparam int MODE_LSB = 5;

	localparam logic [2:0] MODE_SLEEP = 3'h4;
	localparam logic [2:0] MODE_ACTIVE_IDLE = 3'h6;
	localparam logic [2:0] MODE_ACTIVE_ON = 3'h7;

	localparam int CLK_PERIOD_NS = 25;
	localparam int RAMP_TIME_NS = 1000;
	localparam int RAMP_CYCLES = (RAMP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RAMP_WIDTH = 12;

	typedef enum logic [1:0] {
		SEQ_OFF = 2'b00,
		SEQ_RAMP_UP = 2'b01,
		SEQ_ON = 2'b10,
		SEQ_RAMP_DOWN = 2'b11
	} cperg_seq_state_type;

	typedef struct packed {
		cperg_seq_state_type state;
		logic [RAMP_WIDTH-1:0] count;
		logic powered;
	} cperg_seq_type;

	typedef struct packed {
		logic [7:0] input_enable;
		logic [7:0] slot_enable;
		logic [7:0] power_cfg;
		logic [1:0] target;
		logic [2:0] mode;
		logic [7:0] rd_data;
	} cperg_regs_type;
endpackage

// [cperg_chan_seq.sv]
// Power sequencer of one converter channel.
// Assumes the request is a level from the register block on the same clock.
`timescale 1ns/1ps
module cperg_chan_seq #(
	parameter logic [cperg_pkg::RAMP_WIDTH-1:0] RAMP_CYCLES =
		cperg_pkg::RAMP_WIDTH'(cperg_pkg::RAMP_CYCLES)
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic power_request,
	output logic powered
);
	cperg_pkg::cperg_seq_type s_q;
	cperg_pkg::cperg_seq_type s_d;

	always_comb begin
		s_d = s_q;
		case (s_q.state)
			cperg_pkg::SEQ_OFF: begin
				if (power_request) begin
					s_d.state = cperg_pkg::SEQ_RAMP_UP;
					s_d.count = RAMP_CYCLES;
				end
			end
			cperg_pkg::SEQ_RAMP_UP: begin
				// A withdrawn request reverses the ramp at once
				if (!power_request) begin
					s_d.state = cperg_pkg::SEQ_RAMP_DOWN;
					s_d.count = RAMP_CYCLES;
				end else if (s_q.count <= 1) begin
					s_d.state = cperg_pkg::SEQ_ON;
					s_d.powered = 1'b1;
				end else begin
					s_d.count = s_q.count - 1'b1;
				end
			end
			cperg_pkg::SEQ_ON: begin
				if (!power_request) begin
					s_d.state = cperg_pkg::SEQ_RAMP_DOWN;
					s_d.count = RAMP_CYCLES;
				end
			end
			default: begin
				// Status keeps its value until the shutdown ramp has finished, then clears
				if (s_q.count <= 1) begin
					s_d.state = cperg_pkg::SEQ_OFF;
					s_d.powered = 1'b0;
				end else begin
					s_d.count = s_q.count - 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign powered = s_q.powered;
endmodule

// [cperg_regs_asserts.sv]
// Port-level checks of the channel power and enable register block.
// Assumes it is bound into cperg_regs.
`timescale 1ns/1ps
module cperg_regs_asserts #(
	parameter logic [cperg_pkg::RAMP_WIDTH-1:0] RAMP_CYCLES = 12'h028
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic device_sleep,
	input wire logic input_ch1_enable,
	input wire logic input_ch2_enable,
	input wire logic out_slot1_enable,
	input wire logic out_slot2_enable,
	input wire logic mic_bias_power_on,
	input wire logic converter_power_on,
	input wire logic pll_power_on,
	input wire logic dynamic_channel_power_enable,
	input wire logic ch1_powered,
	input wire logic ch2_powered,
	input wire logic [2:0] device_mode_field
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_rise; $rose(ch1_powered) || $rose(ch2_powered); endsequence
	sequence s_dyn_off;
		dynamic_channel_power_enable && converter_power_on && !input_ch2_enable && ch2_powered;
	endsequence
	property p_in; reg_write && reg_addr == 8'h73 |=>
		{input_ch1_enable, input_ch2_enable} == $past(reg_wdata[7:6]); endproperty
	a_in: assert property (p_in) else $error("input enable mismatch");
	property p_slot; reg_write && reg_addr == 8'h74 |=>
		{out_slot1_enable, out_slot2_enable} == $past(reg_wdata[7:6]); endproperty
	a_slot: assert property (p_slot) else $error("slot enable mismatch");
	property p_pwr; reg_write && reg_addr == 8'h75 |=> {mic_bias_power_on, converter_power_on,
		pll_power_on, dynamic_channel_power_enable} == $past(reg_wdata[7:4]); endproperty
	a_pwr: assert property (p_pwr) else $error("power control mismatch");
	property p_hold; !reg_write || reg_addr < 8'h73 || reg_addr > 8'h75 |=> $stable({input_ch1_enable,
		input_ch2_enable, out_slot1_enable, out_slot2_enable, mic_bias_power_on}); endproperty
	a_hold: assert property (p_hold) else $error("control changed without write");
	property p_sts0; reg_read && reg_addr == 8'h76 |=>
		reg_rdata == {$past(ch1_powered), $past(ch2_powered), 6'h00}; endproperty
	a_sts0: assert property (p_sts0) else $error("power status read mismatch");
	property p_sts1; reg_read && reg_addr == 8'h77 |=>
		reg_rdata == {$past(device_mode_field), 5'h00}; endproperty
	a_sts1: assert property (p_sts1) else $error("mode status read mismatch");
	// The edge that releases reset still finds the flops in reset, so it is skipped
	property p_mode; !reset |=> device_mode_field == ($past(device_sleep) ? 3'h4 :
		($past(ch1_powered || ch2_powered) ? 3'h7 : 3'h6)); endproperty
	a_mode: assert property (p_mode) else $error("mode field mismatch");
	property p_up; s_rise |-> $past(converter_power_on, 2); endproperty
	a_up: assert property (p_up) else $error("channel powered too early");
	property p_down; s_dyn_off |-> ##[1:64] !ch2_powered; endproperty
	a_down: assert property (p_down) else $error("dynamic power down missing");
endmodule
bind cperg_regs cperg_regs_asserts #(.RAMP_CYCLES(RAMP_CYCLES)) u_chk (
	.clk(clk),
	.reset(reset),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_write(reg_write),
	.reg_read(reg_read),
	.reg_rdata(reg_rdata),
	.device_sleep(device_sleep),
	.input_ch1_enable(input_ch1_enable),
	.input_ch2_enable(input_ch2_enable),
	.out_slot1_enable(out_slot1_enable),
	.out_slot2_enable(out_slot2_enable),
	.mic_bias_power_on(mic_bias_power_on),
	.converter_power_on(converter_power_on),
	.pll_power_on(pll_power_on),
	.dynamic_channel_power_enable(dynamic_channel_power_enable),
	.ch1_powered(ch1_powered),
	.ch2_powered(ch2_powered),
	.device_mode_field(device_mode_field)
);

// [test_cperg_regs.sv]
// Self-checking bench of the channel power and enable register block.
// Assumes the bench drives the register port itself, no partner model.
`timescale 1ns/1ps
module test_cperg_regs;
	localparam logic [11:0] RAMP = 12'h003;
	logic clk = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0, device_sleep = 1'b1;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic input_ch1_enable, input_ch2_enable, out_slot1_enable, out_slot2_enable;
	logic mic_bias_power_on, converter_power_on, pll_power_on, dynamic_channel_power_enable;
	logic ch1_powered, ch2_powered;
	logic [2:0] device_mode_field;
	logic [31:0] seed = 32'h00005038, r;
	int n_errors = 0, tests_run = 0, cycles = 0;
	cperg_regs #(.RAMP_CYCLES(RAMP)) uut (
		.clk(clk),
		.reset(reset),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_write(reg_write),
		.reg_read(reg_read),
		.reg_rdata(reg_rdata),
		.device_sleep(device_sleep),
		.input_ch1_enable(input_ch1_enable),
		.input_ch2_enable(input_ch2_enable),
		.out_slot1_enable(out_slot1_enable),
		.out_slot2_enable(out_slot2_enable),
		.mic_bias_power_on(mic_bias_power_on),
		.converter_power_on(converter_power_on),
		.pll_power_on(pll_power_on),
		.dynamic_channel_power_enable(dynamic_channel_power_enable),
		.ch1_powered(ch1_powered),
		.ch2_powered(ch2_powered),
		.device_mode_field(device_mode_field)
	);
	always #12.5 clk = ~clk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic wrap_up();
		$display("errors %0d comparisons %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(string name, logic [7:0] e, logic [7:0] got);
		tests_run++;
		if (got !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", name, e, got);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clk);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_write <= 1'b0;
		#1;
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e);
		@(posedge clk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_read <= 1'b0;
		#1;
		chk("reg_rdata", e, reg_rdata);
	endtask
	// Waits a bounded time for the power status pair to reach e
	task automatic wt(logic [1:0] e, int n);
		repeat (n) @(posedge clk);
		for (int i = 0; i < 100 && {ch1_powered, ch2_powered} !== e; i++) begin
			@(posedge clk);
			#1;
		end
		#1;
		chk("powered", {6'h00, e}, {6'h00, ch1_powered, ch2_powered});
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_errors++;
			wrap_up();
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		rd(8'h77, 8'h80);
		@(posedge clk);
		device_sleep <= 1'b0;
		rd(8'h73, 8'hFC);
		rd(8'h74, 8'h00);
		rd(8'h75, 8'h00);
		rd(8'h76, 8'h00);
		rd(8'h77, 8'hC0);
		rd(8'h10, 8'h00);
		wr(8'h76, 8'hFF);
		rd(8'h76, 8'h00);
		for (int i = 0; i < 24; i++) begin
			r = rnd();
			wr(8'h73, {r[7:6], 6'h3C});
			wr(8'h74, {r[5:4], 6'h00});
			wr(8'h75, {r[3], 1'b0, r[2], 5'h00});
			chk("controls", {r[7:3], 1'b0, r[2], 1'b0}, {input_ch1_enable, input_ch2_enable,
				out_slot1_enable, out_slot2_enable, mic_bias_power_on, converter_power_on,
				pll_power_on, dynamic_channel_power_enable});
			rd(8'h73, {r[7:6], 6'h3C});
		end
		wr(8'h73, 8'hFC);
		wr(8'h75, 8'h40);
		chk("powered", 8'h00, {6'h00, ch1_powered, ch2_powered});
		wt(2'b11, 0);
		rd(8'h76, 8'hC0);
		rd(8'h77, 8'hE0);
		chk("mode", 8'h07, {5'h00, device_mode_field});
		wr(8'h73, 8'hBC);
		wt(2'b11, 20);
		wr(8'h75, 8'h50);
		wt(2'b10, 0);
		wr(8'h73, 8'hFC);
		wt(2'b11, 0);
		wr(8'h75, 8'h00);
		wt(2'b00, 0);
		rd(8'h77, 8'hC0);
		// Reset in mid-run while both channels are up
		wr(8'h75, 8'h40);
		wt(2'b11, 0);
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		#1;
		chk("powered", 8'h00, {6'h00, ch1_powered, ch2_powered});
		chk("mode", 8'h04, {5'h00, device_mode_field});
		rd(8'h73, 8'hFC);
		rd(8'h75, 8'h00);
		rd(8'h76, 8'h00);
		rd(8'h77, 8'hC0);
		@(posedge clk);
		device_sleep <= 1'b1;
		rd(8'h77, 8'h80);
		wrap_up();
	end
endmodule
